/* async_host_bus_slave_port_tb.sv */
// self-checking bench for the host bus slave port
`timescale 1ns/1ps
`include "hostport_defines.svh"
module async_host_bus_slave_port_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cs_n, i_irq_ack_n, i_rw, o_host_data_oe, o_xfer_ack_n;
  logic o_xfer_ack_oe, o_rd_strobe, o_wr_strobe, o_vec_strobe, o_cmd_busy;
  logic [3:0] i_reg_select, o_acc_select;
  logic [7:0] i_host_data_bus, o_host_data_bus, o_out_port, o_wr_data;
  logic [7:0] i_rd_data = 8'h5a;
  logic [7:0] i_irq_vector = 8'hc3;
  logic [5:0] i_in_port = 6'h2d;
  logic [5:0] o_in_snapshot;
  logic [7:0] q;
  int st;
  int err_count = 0;
  int comparisons = 0;
  int rd_cnt = 0;
  int vec_cnt = 0;
  int busy_cnt = 0;
  host_bus_port DUT (.*);
  host_model u_host (.i_mclk(i_mclk), .i_ack_n(o_xfer_ack_n),
    .i_ack_oe(o_xfer_ack_oe), .i_dout(o_host_data_bus),
    .i_doe(o_host_data_oe), .o_cs_n(i_cs_n), .o_irq_ack_n_n(i_irq_ack_n),
    .o_rw(i_rw), .o_sel(i_reg_select), .o_bus(i_host_data_bus));
  initial forever #25 i_mclk = ~i_mclk;
  // read and vector strobe pulses and busy cycles are counted so a check after the cycle still sees them
  always @(posedge i_mclk) begin
    if (o_rd_strobe === 1'b1) rd_cnt <= rd_cnt + 1;
    if (o_vec_strobe === 1'b1) vec_cnt <= vec_cnt + 1;
    if (o_cmd_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end
  // ****
  // helpers
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic op(input logic ia, input logic rd, input logic [3:0] s,
    input logic [7:0] d, input int hold);
    u_host.cycle(ia, rd, s, d, hold, q, st);
    if (st == 2) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_read();
    op(1'b0, 1'b1, 4'h0, 8'h00, 40);
    check(8'(st), 8'h01);
    check(q, 8'h5a);
    check(8'(o_in_snapshot), 8'h2d);
    check(8'(rd_cnt), 8'h01);
  endtask
  task automatic t_write();
    op(1'b0, 1'b0, 4'h3, 8'ha5, 40);
    check(8'(st), 8'h01);
    check(o_wr_data, 8'ha5);
    check(8'(o_acc_select), 8'h03);
    check(o_out_port, 8'h00);
  endtask
  task automatic t_port();
    op(1'b0, 1'b0, `SEL_OUT_SET, 8'h81, 40);
    check(o_out_port, 8'h81);
    op(1'b0, 1'b0, `SEL_OUT_CLR, 8'h01, 40);
    check(o_out_port, 8'h80);
  endtask
  // direction low on purpose: the acknowledge cycle must still read
  task automatic t_irq_ack_n();
    op(1'b1, 1'b0, 4'h0, 8'h77, 40);
    check(8'(st), 8'h01);
    check(q, 8'hc3);
    check(o_wr_data, 8'h01);
    check(8'(vec_cnt), 8'h01);
    check(8'(rd_cnt), 8'h01);
  endtask
  // a two-clock select survives the filter as two clocks, so ack still comes
  task automatic t_short();
    op(1'b0, 1'b0, 4'h3, 8'h3c, 2);
    check(8'(st), 8'h01);
    check(o_wr_data, 8'h3c);
  endtask
  task automatic t_cmd();
    op(1'b0, 1'b0, `SEL_CMD_A, 8'h11, 40);
    op(1'b0, 1'b0, `SEL_CMD_A, 8'h22, 40);
    check(o_wr_data, 8'h22);
    op(1'b0, 1'b0, `SEL_CMD_B, 8'h33, 40);
    check(o_wr_data, 8'h33);
    check(8'(busy_cnt), 8'h06);
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    check(8'(o_xfer_ack_oe), 8'h00);
    check(8'(o_host_data_oe), 8'h00);
    #1 i_rst_n = 1'b1;
    t_read();
    t_write();
    t_port();
    t_irq_ack_n();
    t_short();
    t_cmd();
    tally_and_finish();
  end
endmodule // async_host_bus_slave_port_tb

/* host_bus_port.sv */
// host bus slave port: select/ack handshake, data bus, port pins
// Summary of operation
// - acknowledge on clock rising edge after select
// - select held until acknowledge, else may skip
// - write data latched at ack or deselect
// - short select skips ack, latch on deselect
// - irq acknowledge ignores read/write, reads response
// - irq acknowledge drives byte, acknowledges on edge
// - read data driven, released after strobe removed
// - acknowledge negated first, then released
// - input port sampled at select, outputs after
`timescale 1ns/1ps
`include "hostport_defines.svh"
module host_bus_port
  import hostport_pkg::*;
#(
  parameter int DW = `DATA_W,
  parameter int SW = `SEL_W,
  parameter int IW = `IN_PORT_W,
  parameter int OW = `OUT_PORT_W
) (
  input wire logic i_mclk, // osc_clock_in, 20 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_cs_n, // device select pin, active low
  input wire logic i_irq_ack_n, // interrupt acknowledge pin
  input wire logic i_rw, // 1 read, 0 write
  input wire logic [SW-1:0] i_reg_select, // register select pins
  input wire logic [DW-1:0] i_host_data_bus, // data bus pin levels
  output logic [DW-1:0] o_host_data_bus, // data bus drive value
  output logic o_host_data_oe, // data bus drive enable
  output logic o_xfer_ack_n, // transfer acknowledge value
  output logic o_xfer_ack_oe, // transfer acknowledge enable
  input wire logic [IW-1:0] i_in_port, // parallel input pins
  output logic [OW-1:0] o_out_port, // parallel output pins
  input wire logic [DW-1:0] i_rd_data, // user read data for sel
  input wire logic [DW-1:0] i_irq_vector, // interrupt response byte
  output logic [SW-1:0] o_acc_select, // latched register select
  output logic o_rd_strobe, // one-cycle read done pulse
  output logic o_wr_strobe, // one-cycle write pulse
  output logic [DW-1:0] o_wr_data, // latched write data
  output logic o_vec_strobe, // one-cycle irq ack done pulse
  output logic [IW-1:0] o_in_snapshot, // input port at select
  output logic o_cmd_busy // command register still settling
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic cs_n_s;
  logic irq_ack_n_n_s;
  logic rw_s;
  logic [SW-1:0] sel_s;
  logic [DW-1:0] din_s;
  logic [IW-1:0] inp_s;

  pin_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync_strb (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_cs_n, i_irq_ack_n}),
    .o_level({cs_n_s, irq_ack_n_n_s})
  );
  pin_sync #(.WIDTH(1 + SW + DW + IW)) u_sync_bus (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_rw, i_reg_select, i_host_data_bus, i_in_port}),
    .o_level({rw_s, sel_s, din_s, inp_s})
  );

  // ************************************************************
  // cycle sequencer
  // ************************************************************
  port_state_e st_r, st_nxt;
  logic irq_ack_n_cyc_r, irq_ack_n_cyc_nxt;
  logic rd_cyc_r, rd_cyc_nxt;
  logic [SW-1:0] asel_r, asel_nxt;
  logic [DW-1:0] wdat_r, wdat_nxt;
  logic [DW-1:0] dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  logic ack_r, ack_nxt;
  logic aoe_r, aoe_nxt;
  logic rds_r, rds_nxt;
  logic wrs_r, wrs_nxt;
  logic vec_r, vec_nxt;
  logic [IW-1:0] snap_r, snap_nxt;
  logic [OW-1:0] op_r, op_nxt;
  logic [OW-1:0] op_pend_r, op_pend_nxt;
  logic op_upd_r, op_upd_nxt;
  logic [1:0] gap_r, gap_nxt;
  logic busy_r, busy_nxt;
  logic strobe_on;

  // sel and irq_ack_n must not overlap; if they do, sel takes the cycle
  assign strobe_on = !cs_n_s || !irq_ack_n_n_s;

  always_comb begin
    st_nxt = st_r;
    irq_ack_n_cyc_nxt = irq_ack_n_cyc_r;
    rd_cyc_nxt = rd_cyc_r;
    asel_nxt = asel_r;
    wdat_nxt = wdat_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    ack_nxt = ack_r;
    aoe_nxt = aoe_r;
    rds_nxt = 1'b0;
    wrs_nxt = 1'b0;
    vec_nxt = 1'b0;
    snap_nxt = snap_r;
    op_nxt = op_r;
    op_pend_nxt = op_pend_r;
    op_upd_nxt = op_upd_r;
    gap_nxt = (gap_r != 2'h0) ? gap_r - 2'h1 : 2'h0;
    case (st_r)
      ST_IDLE: begin
        aoe_nxt = 1'b0;
        ack_nxt = 1'b1;
        doe_nxt = 1'b0;
        if (strobe_on) begin
          // first edge finding the strobe recognises it
          st_nxt = ST_RECOG;
          irq_ack_n_cyc_nxt = cs_n_s;
          rd_cyc_nxt = cs_n_s ? 1'b1 : rw_s;
          asel_nxt = sel_s;
          snap_nxt = inp_s;
          if (cs_n_s || rw_s) begin
            dout_nxt = cs_n_s ? i_irq_vector : i_rd_data;
            doe_nxt = 1'b1;
          end
        end
      end
      ST_RECOG: begin
        if (!strobe_on) begin
          // removed within one clock: no ack, latch on deselect
          st_nxt = ST_RELEASE;
          doe_nxt = 1'b0;
          if (!rd_cyc_r) begin
            wdat_nxt = din_s;
            wrs_nxt = 1'b1;
          end
        end else begin
          st_nxt = ST_ACK;
          ack_nxt = 1'b0;
          aoe_nxt = 1'b1;
          if (!rd_cyc_r) begin
            wdat_nxt = din_s;
            wrs_nxt = 1'b1;
          end
        end
      end
      ST_ACK: begin
        if (!strobe_on) begin
          st_nxt = ST_NEGATE;
          ack_nxt = 1'b1;
          doe_nxt = 1'b0;
          rds_nxt = rd_cyc_r && !irq_ack_n_cyc_r;
          vec_nxt = irq_ack_n_cyc_r;
        end
      end
      ST_NEGATE: begin
        aoe_nxt = 1'b0;
        st_nxt = ST_RELEASE;
      end
      ST_RELEASE: begin
        aoe_nxt = 1'b0;
        ack_nxt = 1'b1;
        doe_nxt = 1'b0;
        st_nxt = ST_IDLE;
        // output pins follow only once select is gone
        if (op_upd_r) begin
          op_nxt = op_pend_r;
          op_upd_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (wrs_nxt) begin
      if (asel_r == `SEL_OUT_SET) begin
        op_pend_nxt = op_r | wdat_nxt[OW-1:0];
        op_upd_nxt = 1'b1;
      end else if (asel_r == `SEL_OUT_CLR) begin
        op_pend_nxt = op_r & ~wdat_nxt[OW-1:0];
        op_upd_nxt = 1'b1;
      end else if (asel_r == `SEL_CMD_A || asel_r == `SEL_CMD_B) begin
        // each transition is half a clock; round up to whole cycles
        gap_nxt = 2'((`CMD_GAP_TRANSITIONS + 1) / 2);
      end
    end
    // registered so the busy pin comes straight from a flop
    busy_nxt = (gap_nxt != 2'h0);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      irq_ack_n_cyc_r <= 1'b0;
      rd_cyc_r <= 1'b1;
      asel_r <= '0;
      wdat_r <= '0;
      dout_r <= '0;
      doe_r <= 1'b0;
      ack_r <= 1'b1;
      aoe_r <= 1'b0;
      rds_r <= 1'b0;
      wrs_r <= 1'b0;
      vec_r <= 1'b0;
      snap_r <= '0;
      op_r <= '0;
      op_pend_r <= '0;
      op_upd_r <= 1'b0;
      gap_r <= 2'h0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      irq_ack_n_cyc_r <= irq_ack_n_cyc_nxt;
      rd_cyc_r <= rd_cyc_nxt;
      asel_r <= asel_nxt;
      wdat_r <= wdat_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      ack_r <= ack_nxt;
      aoe_r <= aoe_nxt;
      rds_r <= rds_nxt;
      wrs_r <= wrs_nxt;
      vec_r <= vec_nxt;
      snap_r <= snap_nxt;
      op_r <= op_nxt;
      op_pend_r <= op_pend_nxt;
      op_upd_r <= op_upd_nxt;
      gap_r <= gap_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign o_host_data_bus = dout_r;
  assign o_host_data_oe = doe_r;
  assign o_xfer_ack_n = ack_r;
  assign o_xfer_ack_oe = aoe_r;
  assign o_out_port = op_r;
  assign o_acc_select = asel_r;
  assign o_rd_strobe = rds_r;
  assign o_wr_strobe = wrs_r;
  assign o_wr_data = wdat_r;
  assign o_vec_strobe = vec_r;
  assign o_in_snapshot = snap_r;
  assign o_cmd_busy = busy_r;
endmodule // host_bus_port

/* host_bus_port_chk.sv */
// assertions on the host bus slave port pins
`timescale 1ns/1ps
module host_bus_port_chk (
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset, low
  input wire logic i_cs_n, // select
  input wire logic i_irq_ack_n, // irq ack
  input wire logic o_xfer_ack_n, // ack
  input wire logic o_xfer_ack_oe, // ack enable
  input wire logic o_host_data_oe, // data enable
  input wire logic [7:0] o_out_port, // port pins
  input wire logic [3:0] o_acc_select, // select seen
  input wire logic o_wr_strobe, // write pulse
  input wire logic o_cmd_busy // settling
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // checks
  // ****
  sequence s_idle;
    i_cs_n && i_irq_ack_n;
  endsequence
  sequence s_ack_on;
    $fell(o_xfer_ack_n);
  endsequence
  property p_drv;
    !o_xfer_ack_n |-> o_xfer_ack_oe;
  endproperty
  a_drv: assert property (p_drv)
    else $error("ack low undriven");
  property p_hold;
    !o_xfer_ack_n && !i_cs_n |=> !o_xfer_ack_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("ack dropped under select");
  property p_drop;
    !o_xfer_ack_n && i_cs_n && i_irq_ack_n |-> ##[1:8] o_xfer_ack_n;
  endproperty
  a_drop: assert property (p_drop)
    else $error("ack not negated");
  property p_neg;
    $fell(o_xfer_ack_oe) |-> $past(o_xfer_ack_n);
  endproperty
  a_neg: assert property (p_neg)
    else $error("ack released while low");
  // settle time covers sync latency plus negate and release
  property p_float;
    s_idle [*8] |=> !o_xfer_ack_oe && !o_host_data_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("pins still driven when idle");
  property p_wr;
    s_ack_on ##0 !o_host_data_oe |-> o_wr_strobe;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write not latched at ack");
  property p_dend;
    $rose(o_xfer_ack_n) |-> !o_host_data_oe;
  endproperty
  a_dend: assert property (p_dend)
    else $error("data driven after ack end");
  property p_out;
    $changed(o_out_port) |-> o_xfer_ack_n && !o_host_data_oe;
  endproperty
  a_out: assert property (p_out)
    else $error("port moved inside cycle");
  property p_busy;
    o_wr_strobe && (o_acc_select == 4'h2 || o_acc_select == 4'ha) |->
      ##[0:2] o_cmd_busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("command write not busy");
endmodule // host_bus_port_chk
bind host_bus_port host_bus_port_chk u_chk (.*);

/* host_model.sv */
// behavioural host bus master facing the slave port
`timescale 1ns/1ps
module host_model (
  input wire logic i_mclk, // clock
  input wire logic i_ack_n, // ack value
  input wire logic i_ack_oe, // ack enable
  input wire logic [7:0] i_dout, // port data
  input wire logic i_doe, // port data enable
  output logic o_cs_n, // select
  output logic o_irq_ack_n_n, // irq ack
  output logic o_rw, // direction
  output logic [3:0] o_sel, // register select
  output logic [7:0] o_bus // resolved bus
);
  logic [7:0] wd = 8'h00;
  logic wen = 1'b0;
  logic [7:0] last = 8'h00;
  logic ack_lvl;
  // pull-up on ack; a floating bus toggles so stale data never matches
  assign ack_lvl = i_ack_oe ? i_ack_n : 1'b1;
  assign o_bus = i_doe ? i_dout : (wen ? wd : ~last);
  always @(posedge i_mclk) last <= o_bus;
  initial begin
    o_cs_n = 1'b1;
    o_irq_ack_n_n = 1'b1;
    o_rw = 1'b1;
    o_sel = 4'h0;
  end
  task automatic cycle(input logic ia, input logic rd, input logic [3:0] s,
    input logic [7:0] d, input int hold, output logic [7:0] q,
    output int st);
    int n;
    st = 0;
    q = 8'h00;
    @(posedge i_mclk) #1;
    o_sel = s;
    o_rw = rd;
    wd = d;
    wen = !rd && !ia;
    @(posedge i_mclk) #1;
    if (ia) o_irq_ack_n_n = 1'b0;
    else o_cs_n = 1'b0;
    for (n = 0; n < hold && st == 0; n++) begin
      @(posedge i_mclk);
      if (ack_lvl === 1'b0) begin
        st = 1;
        q = o_bus;
      end
    end
    #1 o_cs_n = 1'b1;
    o_irq_ack_n_n = 1'b1;
    @(posedge i_mclk) #1 wen = 1'b0;
    for (n = 0; n < 12; n++) begin
      @(posedge i_mclk);
      if (ack_lvl === 1'b0) st = 1;
    end
    if (i_ack_oe !== 1'b0) st = 2;
  endtask
endmodule // host_model

/* hostport_defines.svh */
// constants for the asynchronous host bus slave port
`ifndef HOSTPORT_DEFINES_SVH
`define HOSTPORT_DEFINES_SVH
`define DATA_W 8
`define SEL_W 4
`define IN_PORT_W 6
`define OUT_PORT_W 8
`define SYNC_STAGES 3
// register select codes reached through the user side
`define SEL_CMD_A 4'h2
`define SEL_CMD_B 4'ha
`define SEL_IN_PORT 4'hd
`define SEL_OUT_SET 4'he
`define SEL_OUT_CLR 4'hf
// clock transitions required between writes to one command register
`define CMD_GAP_TRANSITIONS 3
`endif

/* hostport_pkg.sv */
// types for the asynchronous host bus slave port
package hostport_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECOG = 3'b001,
    ST_ACK = 3'b010,
    ST_NEGATE = 3'b011,
    ST_RELEASE = 3'b100
  } port_state_e;
endpackage

/* pin_sync.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_mclk, // device clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] i_async, // raw pin level
  output logic [WIDTH-1:0] o_level // filtered level
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;
  logic [WIDTH-1:0] lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      lvl_r <= RESET_VAL;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
endmodule // pin_sync
